// ===== hw/pci_target_consts.vh
// constants for the bus target front end and its serial configuration loader
// assumes a single 50 MHz clock and a synchronous active-high reset
`ifndef PCI_TARGET_CONSTS_VH
`define PCI_TARGET_CONSTS_VH

// bus commands
`define CMD_SPECIAL 4'h1
`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_CFG_READ 4'hA
`define CMD_CFG_WRITE 4'hB

// io window decode: upper address bits compared with the base register
`define IO_BASE_MASK 32'hFFFFFFF8
`define CFG_BASE_W_IDX 4'h4
`define CFG_WORDS 16
`define CFG_BYTES 64

// defaults loaded when the serial memory is disabled (arbitrary identity values)
`define DFLT_ID_WORD 32'h00010001
`define DFLT_CLASS_WORD 32'h07010201
`define DFLT_INT_WORD 32'h00000100
`define DFLT_BASE_WORD 32'h00000001

// serial memory read command, 8 bits, followed by 8 address bits
`define EE_READ_CMD 8'h03
`define EE_DIV 8'h04

`endif

// ===== hw/eeprom_loader.v
// serial configuration loader: reads 64 bytes from a serial memory after reset
// assumes a bit-serial memory that shifts msb first and returns data after command and address
`timescale 1ns/1ps
`include "pci_target_consts.vh"

module eeprom_loader (
  input wire clk_in,
  input wire rst_in,
  input wire load_enable_in,
  input wire data_from_memory_in,
  output reg select_out,
  output reg serial_clock_out,
  output reg data_to_memory_out,
  output reg byte_valid_out,
  output reg [5:0] byte_index_out,
  output reg [7:0] byte_data_out,
  output reg done_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CMD = 2'h1;
  localparam ST_READ = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [1:0] state_r;
  reg [7:0] div_r;
  reg [4:0] bit_r;
  reg [15:0] shift_r;
  reg [9:0] rd_bits_r;
  reg [7:0] rx_r;
  wire tick;
  wire [15:0] cmd_word;

  // read command followed by the start address of the first byte
  assign cmd_word = {`EE_READ_CMD, 8'h00};

  // divider gives a one-cycle enable per serial half period
  assign tick = (div_r == `EE_DIV - 8'h01);

  always @(posedge clk_in) begin
    if (rst_in) begin
      div_r <= 8'h00;
    end else if (tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // one command then a sequential read of all bytes
  always @(posedge clk_in) begin
    byte_valid_out <= 1'b0;
    if (rst_in) begin
      state_r <= ST_IDLE;
      select_out <= 1'b0;
      serial_clock_out <= 1'b0;
      data_to_memory_out <= 1'b0;
      byte_index_out <= 6'h00;
      byte_data_out <= 8'h00;
      done_out <= 1'b0;
      bit_r <= 5'h00;
      shift_r <= 16'h0000;
      rd_bits_r <= 10'h000;
      rx_r <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (!load_enable_in) begin
            state_r <= ST_DONE;
            done_out <= 1'b1;
          end else if (tick) begin
            select_out <= 1'b1;
            data_to_memory_out <= cmd_word[15];
            shift_r <= {cmd_word[14:0], 1'b0};
            bit_r <= 5'h10;
            state_r <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (tick) begin
            serial_clock_out <= ~serial_clock_out;
            // data moves only as the clock falls, so it stands still across each rise
            if (serial_clock_out) begin
              bit_r <= bit_r - 5'h01;
              if (bit_r == 5'h01) begin
                state_r <= ST_READ;
                rd_bits_r <= 10'h000;
              end else begin
                data_to_memory_out <= shift_r[15];
                shift_r <= {shift_r[14:0], 1'b0};
              end
            end
          end
        end
        ST_READ: begin
          if (tick) begin
            serial_clock_out <= ~serial_clock_out;
            if (!serial_clock_out) begin
              rx_r <= {rx_r[6:0], data_from_memory_in};
              rd_bits_r <= rd_bits_r + 10'h001;
              if (rd_bits_r[2:0] == 3'h7) begin
                byte_valid_out <= 1'b1;
                byte_index_out <= rd_bits_r[8:3];
                byte_data_out <= {rx_r[6:0], data_from_memory_in};
                if (rd_bits_r[8:3] == 6'h3F) begin
                  state_r <= ST_DONE;
                  select_out <= 1'b0;
                  done_out <= 1'b1;
                end
              end
            end
          end
        end
        ST_DONE: begin
          serial_clock_out <= 1'b0;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // eeprom_loader

// ===== hw/pci_target.v
// bus target front end: claims io and configuration cycles, parity, errors, interrupt
// assumes bus pins sampled synchronous to clk_in; two-way pins split into in, out, enable
`timescale 1ns/1ps
`include "pci_target_consts.vh"

module pci_target (
  input wire clk_in,
  input wire rst_in,
  input wire [31:0] ad_in,
  output reg [31:0] ad_out,
  output reg ad_oe_out,
  input wire [3:0] cbe_n_in,
  input wire par_in,
  output reg par_out,
  output reg par_oe_out,
  input wire frame_n_in,
  input wire irdy_n_in,
  input wire idsel_in,
  output reg trdy_n_out,
  output reg devsel_n_out,
  output reg stop_n_out,
  output reg ctl_oe_out,
  output reg perr_n_out,
  output reg perr_oe_out,
  output reg serr_oe_out,
  output reg inta_oe_out,
  output wire eeprom_select_out,
  output wire eeprom_serial_clock_out,
  output wire eeprom_data_to_memory_out,
  input wire eeprom_data_from_memory_in,
  input wire eeprom_load_enable_in,
  input wire peripheral_acknowledge_n_in,
  input wire standard_printer_mode_in,
  input wire printer_int_enable_in,
  output reg [2:0] io_addr_out,
  output reg [3:0] io_byte_en_out,
  output reg [31:0] io_wdata_out,
  output reg io_write_out,
  input wire [31:0] io_rdata_in
);
  // idle waits for an address phase, data runs the claimed transfer,
  // busy holds stop for a retry or disconnect, turn drives the controls high for one clock (stop stays low after a two-phase config burst)
  localparam ST_IDLE = 3'h0;
  localparam ST_DATA = 3'h1;
  localparam ST_TURN = 3'h2;
  localparam ST_BUSY = 3'h3;

  reg [2:0] state_r;
  reg [31:0] addr_r;
  reg [3:0] cmd_r;
  reg cfg_r;
  // configuration space kept in flip-flops, one word per entry
  reg [31:0] cfg_mem_r [0:`CFG_WORDS-1];
  reg frame_q_r;
  reg [31:0] ad_q_r;
  reg [3:0] cbe_q_r;
  reg chk_r;
  reg chk_addr_r;
  reg rd_par_r;
  wire ld_valid;
  wire [5:0] ld_idx;
  wire [7:0] ld_data;
  wire ld_done;
  wire addr_phase;
  wire io_hit;
  wire cfg_hit;
  wire is_read;
  wire xfer;
  wire [31:0] base;
  wire [3:0] cmd_in;
  wire cmd_is_read;
  wire [3:0] rd_idx;
  wire [31:0] rd_word;
  wire [31:0] cfg_wr_word;
  wire [3:0] lane_en;
  wire q_par;
  wire par_bad;
  wire int_cond;
  wire bus_idle;

  eeprom_loader loader (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_enable_in(eeprom_load_enable_in),
    .data_from_memory_in(eeprom_data_from_memory_in),
    .select_out(eeprom_select_out),
    .serial_clock_out(eeprom_serial_clock_out),
    .data_to_memory_out(eeprom_data_to_memory_out),
    .byte_valid_out(ld_valid),
    .byte_index_out(ld_idx),
    .byte_data_out(ld_data),
    .done_out(ld_done)
  );

  // the bus counts as idle only with frame, initiator ready, our target ready and device select all high;
  // frame is taken from its previous sample so a frame held low never looks like a new start
  assign bus_idle = frame_q_r && irdy_n_in && trdy_n_out && devsel_n_out;
  // a new transaction starts when frame falls on an idle bus
  assign addr_phase = (state_r == ST_IDLE) && !frame_n_in && bus_idle;
  assign cmd_in = cbe_n_in;
  assign base = cfg_mem_r[`CFG_BASE_W_IDX];
  assign io_hit = ((cmd_in == `CMD_IO_READ) || (cmd_in == `CMD_IO_WRITE)) &&
                  ((ad_in & `IO_BASE_MASK) == (base & `IO_BASE_MASK));
  assign cfg_hit = idsel_in && (ad_in[1:0] == 2'h0) &&
                   ((cmd_in == `CMD_CFG_READ) || (cmd_in == `CMD_CFG_WRITE));
  assign is_read = (cmd_r == `CMD_IO_READ) || (cmd_r == `CMD_CFG_READ);
  assign xfer = (state_r == ST_DATA) && !irdy_n_in && !trdy_n_out;

  // read data is fetched at the claim so it already stands on the bus when target ready is
  // first sampled; after each transfer the next config word is fetched, while io reads take io_rdata_in as it stands
  assign cmd_is_read = (cmd_in == `CMD_IO_READ) || (cmd_in == `CMD_CFG_READ);
  assign rd_idx = addr_phase ? ad_in[5:2] : (addr_r[5:2] + {3'h0, xfer});
  assign rd_word = (addr_phase ? cfg_hit : cfg_r) ? cfg_mem_r[rd_idx] : io_rdata_in;

  // config writes honour the byte enables lane by lane; the space flag bits stay fixed
  assign lane_en = ~cbe_n_in;
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl = gl + 1) begin : g_lane
      assign cfg_wr_word[gl*8 +: 8] = lane_en[gl] ? ad_in[gl*8 +: 8] :
                                      cfg_mem_r[`CFG_BASE_W_IDX][gl*8 +: 8];
    end
  endgenerate

  // checked parity uses the captured phase, since the initiator sends parity a clock late
  assign q_par = ^{ad_q_r, cbe_q_r};
  assign par_bad = (q_par != par_in);

  // interrupt cause is a level, so the pin releases one clock after acknowledge returns high
  assign int_cond = standard_printer_mode_in && printer_int_enable_in &&
                    !peripheral_acknowledge_n_in;

  // built-in defaults for the no-load case; the loader overwrites every word when enabled,
  // so a sparse default table costs nothing once the serial memory is fitted
  function [31:0] dflt_word;
    input integer idx;
    begin
      case (idx)
        0: dflt_word = `DFLT_ID_WORD;
        2: dflt_word = `DFLT_CLASS_WORD;
        4: dflt_word = `DFLT_BASE_WORD;
        15: dflt_word = `DFLT_INT_WORD;
        default: dflt_word = 32'h00000000;
      endcase
    end
  endfunction

  // configuration words: defaults at reset, loader bytes little-endian, base writable
  genvar gi;
  generate
    for (gi = 0; gi < `CFG_WORDS; gi = gi + 1) begin : g_cfg
      always @(posedge clk_in) begin
        if (rst_in) begin
          cfg_mem_r[gi] <= dflt_word(gi);
        end else if (ld_valid && (ld_idx[5:2] == gi)) begin
          cfg_mem_r[gi][ld_idx[1:0]*8 +: 8] <= ld_data;
        end else if (xfer && cfg_r && !is_read && (addr_r[5:2] == gi) &&
                     (gi == `CFG_BASE_W_IDX)) begin
          cfg_mem_r[gi] <= {cfg_wr_word[31:3], 3'h1};
        end
      end
    end
  endgenerate

  // target sequencer: claim, wait-free data phases, burst address, release
  // claiming on the first clock keeps the decode fast; the cost is that read data
  // must be fetched combinationally at the claim edge
  always @(posedge clk_in) begin
    frame_q_r <= frame_n_in;
    io_write_out <= 1'b0;
    if (rst_in) begin
      state_r <= ST_IDLE;
      addr_r <= 32'h00000000;
      cmd_r <= 4'h0;
      cfg_r <= 1'b0;
      frame_q_r <= 1'b1;
      trdy_n_out <= 1'b1;
      devsel_n_out <= 1'b1;
      stop_n_out <= 1'b1;
      ctl_oe_out <= 1'b0;
      ad_out <= 32'h00000000;
      ad_oe_out <= 1'b0;
      io_addr_out <= 3'h0;
      io_byte_en_out <= 4'h0;
      io_wdata_out <= 32'h00000000;
    end else begin
      case (state_r)
        // idle: watch for an address phase that hits our window or our id select
        ST_IDLE: begin
          if (addr_phase && (io_hit || cfg_hit)) begin
            addr_r <= ad_in;
            cmd_r <= cmd_in;
            cfg_r <= cfg_hit;
            devsel_n_out <= 1'b0;
            ctl_oe_out <= 1'b1;
            if (cfg_hit && !ld_done) begin
              stop_n_out <= 1'b0;
              state_r <= ST_BUSY;
            end else begin
              trdy_n_out <= 1'b0;
              ad_out <= rd_word;
              ad_oe_out <= cmd_is_read;
              state_r <= ST_DATA;
            end
          end
        end
        // data: one transfer per clock in which both ready lines are low
        ST_DATA: begin
          ad_oe_out <= is_read;
          ad_out <= rd_word;
          io_addr_out <= addr_r[2:0];
          if (xfer) begin
            io_byte_en_out <= ~cbe_n_in;
            io_wdata_out <= ad_in;
            io_write_out <= !cfg_r && !is_read;
            addr_r <= addr_r + 32'h00000004;
            if (frame_n_in) begin
              trdy_n_out <= 1'b1;
              devsel_n_out <= 1'b1;
              ad_oe_out <= 1'b0;
              state_r <= ST_TURN;
            end else if (cfg_r) begin
              stop_n_out <= 1'b0;
            end
            if (!frame_n_in && !stop_n_out) begin
              trdy_n_out <= 1'b1;
              ad_oe_out <= 1'b0;
              state_r <= ST_BUSY;
            end
          end else if (!stop_n_out && frame_n_in && !irdy_n_in) begin
            state_r <= ST_TURN;
            ad_oe_out <= 1'b0;
            trdy_n_out <= 1'b1;
            devsel_n_out <= 1'b1;
            stop_n_out <= 1'b1;
          end
        end
        ST_BUSY: begin
          // retry or disconnect: hold stop until the initiator drops frame while holding initiator ready low
          if (frame_n_in && !irdy_n_in) begin
            devsel_n_out <= 1'b1;
            stop_n_out <= 1'b1;
            state_r <= ST_TURN;
          end
        end
        ST_TURN: begin
          // one clock of driven-high turnaround before releasing controls, except stop, still low after a two-phase config burst
          ctl_oe_out <= 1'b0;
          stop_n_out <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // parity: generate on reads, check addresses and write data one clock later
  // a data phase and its parity never share a clock, so both sides compare captured copies
  always @(posedge clk_in) begin
    ad_q_r <= ad_in;
    cbe_q_r <= cbe_n_in;
    if (rst_in) begin
      par_out <= 1'b0;
      par_oe_out <= 1'b0;
      rd_par_r <= 1'b0;
      chk_r <= 1'b0;
      chk_addr_r <= 1'b0;
      perr_n_out <= 1'b1;
      perr_oe_out <= 1'b0;
      serr_oe_out <= 1'b0;
    end else begin
      rd_par_r <= xfer && is_read;
      par_oe_out <= rd_par_r || (ad_oe_out && (state_r == ST_DATA));
      par_out <= ^{ad_out, cbe_n_in};
      chk_addr_r <= addr_phase && (cmd_in != `CMD_SPECIAL);
      chk_r <= xfer && !is_read;
      perr_n_out <= 1'b1;
      if (chk_r && par_bad) begin
        perr_n_out <= 1'b0;
      end
      perr_oe_out <= chk_r || !perr_n_out;
      serr_oe_out <= chk_addr_r && par_bad;
    end
  end

  // interrupt follows acknowledge level in standard printer mode with the printer interrupt enabled
  always @(posedge clk_in) begin
    if (rst_in) begin
      inta_oe_out <= 1'b0;
    end else begin
      inta_oe_out <= int_cond;
    end
  end
endmodule // pci_target

// ===== bench/pci_target_chk.sv
// port checker for the bus target front end
// assumes it is bound to pci_target; one clock, reset high
`timescale 1ns/1ps
module pci_target_chk (
  input wire clk_in,
  input wire rst_in,
  input wire [31:0] ad_out,
  input wire ad_oe_out,
  input wire [3:0] cbe_n_in,
  input wire frame_n_in,
  input wire irdy_n_in,
  input wire idsel_in,
  input wire trdy_n_out,
  input wire devsel_n_out,
  input wire par_out,
  input wire par_oe_out,
  input wire serr_oe_out,
  input wire inta_oe_out,
  input wire standard_printer_mode_in,
  input wire printer_int_enable_in,
  input wire peripheral_acknowledge_n_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_reset_quiet: assert property ($fell(rst_in) |-> !ad_oe_out && !serr_oe_out)
    else $error("bus outputs driven after reset");
  a_claim_after_addr: assert property ($fell(devsel_n_out) |->
    $past(frame_n_in, 2) && !$past(frame_n_in)) else $error("claim without address phase");
  a_cfg_needs_idsel: assert property ($fell(devsel_n_out) &&
    $past(cbe_n_in[3:1]) == 3'h5 |-> $past(idsel_in)) else $error("cfg claim without idsel");
  a_trdy_with_devsel: assert property (!trdy_n_out |-> !devsel_n_out)
    else $error("target ready without device select");
  a_trdy_holds: assert property (!trdy_n_out && irdy_n_in && !devsel_n_out |=> !trdy_n_out)
    else $error("target ready dropped before transfer");
  a_last_release: assert property (!trdy_n_out && !irdy_n_in && frame_n_in |=>
    trdy_n_out && devsel_n_out) else $error("no release after last transfer");
  a_read_parity: assert property ($past(trdy_n_out) == 1'h0 && $past(irdy_n_in) == 1'h0
    && $past(ad_oe_out) |-> par_oe_out && par_out == (^$past(ad_out) ^ ^$past(cbe_n_in)))
    else $error("read parity wrong");
  a_idle_no_claim: assert property (frame_n_in && devsel_n_out |=> devsel_n_out)
    else $error("claim on idle bus");
  a_intr_follow: assert property (standard_printer_mode_in && printer_int_enable_in |=>
    inta_oe_out == !$past(peripheral_acknowledge_n_in)) else $error("interrupt not tracking");
  a_intr_off: assert property (!(standard_printer_mode_in && printer_int_enable_in) |=>
    !inta_oe_out) else $error("interrupt without cause");
endmodule // pci_target_chk

// ===== bench/eeprom_model.sv
// serial memory model answering the configuration loader
// assumes command and address shift in msb first, data shifts out on falling clock
`timescale 1ns/1ps
module eeprom_model (
  input wire select_in,
  input wire serial_clock_in,
  input wire data_in,
  output logic data_out
);
  logic [15:0] head = 16'h0;
  logic [7:0] byte_now;
  int nbits = 0;
  initial data_out = 1'b1;
  // a new frame restarts the bit count
  always @(posedge select_in) nbits = 0;
  // command then start address are taken on the rising clock
  always @(posedge serial_clock_in) begin
    if (select_in) begin
      if (nbits < 16) head = {head[14:0], data_in};
      nbits++;
    end
  end
  // bytes follow in address order; content is the address folded with a pattern
  always @(negedge serial_clock_in) begin
    if (select_in && nbits >= 16) begin
      byte_now = (head[7:0] + 8'((nbits - 16) / 8)) ^ 8'h5A;
      data_out <= byte_now[7 - (nbits - 16) % 8];
    end
  end
  // released line must not keep the last bit, so it flips
  always @(negedge select_in) data_out <= ~data_out;
endmodule // eeprom_model

// ===== bench/testbench.sv
// self-checking bench: bus master tasks, serial memory model, port checker
// assumes pci_target and its constants header are compiled alongside
`timescale 1ns/1ps
`include "pci_target_consts.vh"
module testbench;
  logic clk_in = 0, rst_in = 1, frame_n_in = 1, irdy_n_in = 1, idsel_in = 1, par = 0;
  logic eeprom_load_enable_in = 1, peripheral_acknowledge_n_in = 1, bad = 0, bad_a = 0;
  logic standard_printer_mode_in = 0, printer_int_enable_in = 0, bad_d = 0;
  logic [31:0] ad_drv = 32'h0, io_rdata_in = 32'hC3A55A3C, rd;
  logic [3:0] cbe_n_in = 4'hF, be_seen;
  wire [31:0] ad_out, io_wdata_out;
  wire [2:0] io_addr_out;
  wire [3:0] io_byte_en_out;
  wire ad_oe_out, par_out, par_oe_out, trdy_n_out, devsel_n_out, stop_n_out, ctl_oe_out;
  wire perr_n_out, perr_oe_out, serr_oe_out, inta_oe_out, eeprom_select_out, io_write_out;
  wire eeprom_serial_clock_out, eeprom_data_to_memory_out, eeprom_data_from_memory_in;
  wire [31:0] ad_in = ad_oe_out ? ad_out : ad_drv;
  wire par_in = par_oe_out ? par_out : par;
  int num_errors = 0, samples_checked = 0, got;
  logic stopped, par_seen, perr_seen = 0, serr_seen = 0;
  logic [31:0] wq[$];
  logic [2:0] aq[$];

  pci_target i_dut (.*);
  eeprom_model i_mem (.select_in(eeprom_select_out), .serial_clock_in(eeprom_serial_clock_out),
    .data_in(eeprom_data_to_memory_out), .data_out(eeprom_data_from_memory_in));

  always #10 clk_in = ~clk_in;
  // master parity lags its phase by one clock; bad flips it on purpose
  always @(posedge clk_in) par <= ^{ad_in, cbe_n_in} ^ bad;
  // error lines and write strobes are latched so tasks can judge them later
  always @(posedge clk_in) begin
    if (perr_oe_out && perr_n_out === 1'b0) perr_seen <= 1;
    if (serr_oe_out === 1'b1) serr_seen <= 1;
    if (io_write_out === 1'b1) begin
      wq.push_back(io_wdata_out);
      aq.push_back(io_addr_out);
      be_seen <= io_byte_en_out;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // one transaction; w puts one initiator wait state in the first data phase
  task automatic bus(input logic [3:0] cmd, input logic [31:0] a, d, input logic [3:0] be,
    input int n, w);
    int k;
    begin
      got = 0;
      stopped = 0;
      k = 0;
      @(posedge clk_in);
      frame_n_in <= 0;
      ad_drv <= a;
      cbe_n_in <= cmd;
      bad <= bad_a;
      @(posedge clk_in);
      irdy_n_in <= (w != 0);
      frame_n_in <= (n == 1);
      ad_drv <= d;
      cbe_n_in <= be;
      bad <= bad_d;
      while (k < 10 && got < n && !stopped) begin
        @(posedge clk_in);
        k++;
        if (trdy_n_out === 1'b0 && irdy_n_in === 1'b0) begin
          got++;
          rd = ad_out;
          if (got < n) begin
            ad_drv <= d + got;
            frame_n_in <= (got == n - 1);
          end
        end else if (stop_n_out === 1'b0) stopped = 1;
        else irdy_n_in <= 0;
      end
      frame_n_in <= 1;
      irdy_n_in <= 1;
      bad <= 0;
      @(posedge clk_in);
      par_seen = par_out;
      repeat (2) @(posedge clk_in);
    end
  endtask

  task automatic do_reset(input logic en);
    rst_in <= 1;
    eeprom_load_enable_in <= en;
    repeat (5) @(posedge clk_in);
    chk("ad enable in reset", 1'h0, ad_oe_out);
    chk("serr in reset", 1'h0, serr_oe_out);
    rst_in <= 0;
    repeat (2) @(posedge clk_in);
  endtask

  // config cycles are retried until the loader is through
  task automatic wait_load;
    got = 0;
    for (int i = 0; i < 200 && got == 0; i++) begin
      repeat (100) @(posedge clk_in);
      bus(`CMD_CFG_READ, 32'h0, 32'h0, 4'h0, 1, 0);
    end
    chk("load finished", 1'h1, got);
  endtask

  task automatic t_loader;
    for (int i = 0; i < 20 && eeprom_select_out !== 1'b1; i++) @(posedge clk_in);
    chk("eeprom select", 1'h1, eeprom_select_out);
    bus(`CMD_CFG_READ, 32'h0, 32'h0, 4'h0, 1, 0);
    chk("early cfg stop", 1'h1, stopped);
    chk("early cfg transfers", 32'h0, got);
    wait_load;
    chk("loaded id word", 32'h59585B5A, rd);
    $display("test loader done");
  endtask

  task automatic t_config;
    bus(`CMD_CFG_WRITE, 32'h10, 32'h101, 4'h0, 1, 0);
    bus(`CMD_CFG_READ, 32'h10, 32'h0, 4'h0, 1, 0);
    chk("base readback", 32'h101, rd);
    idsel_in <= 0;
    bus(`CMD_CFG_READ, 32'h10, 32'h0, 4'h0, 1, 0);
    chk("cfg without idsel", 32'h0, got);
    idsel_in <= 1;
    $display("test config done");
  endtask

  task automatic t_io;
    wq.delete();
    aq.delete();
    bus(`CMD_IO_WRITE, 32'h100, 32'h12345678, 4'h5, 2, 1);
    chk("burst count", 32'h2, wq.size());
    chk("write word 0", 32'h12345678, wq[0]);
    chk("write word 1", 32'h12345679, wq[1]);
    chk("burst address step", aq[0] + 3'h4, aq[1]);
    chk("byte lanes", 4'hA, be_seen);
    bus(`CMD_IO_READ, 32'h104, 32'h0, 4'h0, 1, 0);
    chk("read data", io_rdata_in, rd);
    chk("read parity", ^io_rdata_in, par_seen);
    bus(`CMD_IO_READ, 32'h200, 32'h0, 4'h0, 1, 0);
    chk("miss claimed", 32'h0, got);
    $display("test io done");
  endtask

  task automatic t_parity;
    bad_a = 1;
    bus(`CMD_IO_WRITE, 32'h100, 32'h0, 4'h0, 1, 0);
    bad_a = 0;
    chk("address parity error", 1'h1, serr_seen);
    chk("no data parity error", 1'h0, perr_seen);
    bad_d = 1;
    bus(`CMD_IO_WRITE, 32'h100, 32'h0, 4'h0, 1, 0);
    bad_d = 0;
    chk("data parity error", 1'h1, perr_seen);
    $display("test parity done");
  endtask

  task automatic t_intr;
    @(posedge clk_in);
    standard_printer_mode_in <= 1;
    printer_int_enable_in <= 1;
    peripheral_acknowledge_n_in <= 0;
    repeat (2) @(posedge clk_in);
    chk("interrupt on ack", 1'h1, inta_oe_out);
    peripheral_acknowledge_n_in <= 1;
    repeat (2) @(posedge clk_in);
    chk("interrupt after ack", 1'h0, inta_oe_out);
    printer_int_enable_in <= 0;
    peripheral_acknowledge_n_in <= 0;
    repeat (2) @(posedge clk_in);
    chk("interrupt masked", 1'h0, inta_oe_out);
    $display("test interrupt done");
  endtask

  task automatic t_default;
    do_reset(0);
    wait_load;
    chk("default id word", `DFLT_ID_WORD, rd);
    $display("test defaults done");
  endtask

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    do_reset(1);
    t_loader;
    t_config;
    t_io;
    t_parity;
    t_intr;
    t_default;
    tally_and_finish;
  end

  // two loads at most take well under this span
  initial begin
    #1600000;
    num_errors++;
    $display("watchdog expired");
    tally_and_finish;
  end
endmodule // testbench

bind pci_target pci_target_chk i_chk (.*);
